// file: pkg/timer_count_defs.svh
// Constants for the prescaled, postscaled timer-counter.
// Assumes the includer uses them at the widths noted beside each one.
// Behaviour
// RULE1: Prescaler offers sixteen power-of-two divisions from 1:1 to 1:32768.
// RULE2: Prescaler count has no address; software cannot read or write it.
// RULE3: Prescaler clears on low byte write, control write, or reset.
// RULE4: Postscaler offers sixteen divisions 1:1 to 1:16 via postscale select.
// RULE5: Postscaler count hidden; cleared by low byte write, control write, reset.
// RULE6: Sleep stops synchronous counting; asynchronous counting continues and may wake.
// RULE7: Eight-bit mode matches when low byte equals compare high byte.
// RULE8: Sixteen-bit mode event when count wraps from all ones to zero.
// RULE9: Flag sets once every postscale select plus one events.
// RULE10: Enabled interrupt with set flag interrupts processor and may wake.
// RULE11: Pulse output lasts one postscaled period per match or rollover; the code drives it high for one clock cycle.
// RULE12: Timer output toggles on each pulse rising edge, fifty percent duty.
// RULE13: Software reads timer output level through read-only status bit.
// RULE14: Timer output is offered to other peripherals as trigger.
// RULE15: Timer output may be routed to any pin via output select.
// RULE16: Eight-bit mode low byte returns to zero after a match.
// RULE17: Counter advances per prescaler edge when enabled, holds when disabled.
`ifndef TIMER_COUNT_DEFS_SVH
`define TIMER_COUNT_DEFS_SVH
`define TIMER_COUNT_PRESCALE_W 15
`define TIMER_COUNT_PRESCALE_SEL_W 4
`define TIMER_COUNT_POSTSCALE_SEL_W 4
`define TIMER_COUNT_COUNT_RESET 16'h0000
`define TIMER_COUNT_COUNT_MAX 16'hffff
`define TIMER_COUNT_PIN_SEL_W 4
`endif

// file: pkg/timer_count_pkg.sv
// Types shared by the timer-counter design files.
// Assumes timer_count_defs.svh is on the include path.
`default_nettype none
`include "timer_count_defs.svh"
package timer_count_pkg;
    typedef struct packed {
        logic enable;
        logic mode_16bit;
        logic async_clk;
        logic [`TIMER_COUNT_POSTSCALE_SEL_W-1:0] postscale_select;
        logic [`TIMER_COUNT_PRESCALE_SEL_W-1:0] prescale_select;
    } timer_count_cfg_t;
    typedef struct packed {
        logic wr_low;
        logic wr_high;
        logic wr_ctrl;
        logic [7:0] data;
    } timer_count_wr_t;
endpackage
`default_nettype wire

// file: hdl/timer_count_prescaler.sv
// Power-of-two prescaler producing a one-cycle tick per divided period.
// Assumes a clear pulse from its parent on the writes that reset it.
`default_nettype none
`include "timer_count_defs.svh"
module timer_count_prescaler #(
    parameter int WIDTH = `TIMER_COUNT_PRESCALE_W
) (
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic i_run,
    input wire logic i_clear,
    input wire logic [`TIMER_COUNT_PRESCALE_SEL_W-1:0] i_select,
    output logic o_tick
);
    logic [WIDTH-1:0] cnt_q;
    logic [WIDTH-1:0] cnt_d;
    logic [WIDTH-1:0] limit;
    always_comb begin
        // Divide by 2^select; the count is internal only. [RULE1] [RULE2]
        limit = WIDTH'((32'h1 << i_select) - 32'h1);
        cnt_d = cnt_q;
        o_tick = 1'b0;
        if (i_clear) begin
            cnt_d = '0; // [RULE3]
        end else if (i_run) begin
            if (cnt_q >= limit) begin
                cnt_d = '0;
                o_tick = 1'b1;
            end else begin
                cnt_d = cnt_q + WIDTH'(1);
            end
        end
    end
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            cnt_q <= '0; // [RULE3]
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule
`default_nettype wire

// file: hdl/timer_count_timer.sv
// Timer-counter top: prescaler, 8/16-bit counter, postscaler, outputs.
// Assumes software writes arrive as single-cycle strobes on i_wr.
`default_nettype none
`include "timer_count_defs.svh"
module timer_count_timer #(
    parameter int PINS = 16
) (
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire timer_count_pkg::timer_count_cfg_t i_cfg,
    input wire timer_count_pkg::timer_count_wr_t i_wr,
    input wire logic i_sleep,
    input wire logic i_irq_enable,
    input wire logic i_flag_clear,
    input wire logic [PINS-1:0] i_pin_select,
    output logic [15:0] o_timer_count,
    output logic o_timer_irq_flag,
    output logic o_irq,
    output logic o_wake,
    output logic o_timer_pulse_out,
    output logic o_timer_out,
    output logic o_out_status,
    output logic o_adc_trigger,
    output logic [PINS-1:0] o_pin_out
);
    logic [15:0] count_q, count_d;
    logic [`TIMER_COUNT_POSTSCALE_SEL_W-1:0] post_q, post_d;
    logic flag_q, flag_d, pulse_q, pulse_d, out_q, out_d;
    logic irq_q, wake_q, adc_q;
    logic [PINS-1:0] pin_q;
    logic clr, run, tick, event_hit, post_hit;
    assign clr = i_wr.wr_low | i_wr.wr_ctrl; // [RULE3] [RULE5]
    // Synchronous clocking halts in sleep; asynchronous keeps going. [RULE6] [RULE17]
    assign run = i_cfg.enable & ~(i_sleep & ~i_cfg.async_clk);
    timer_count_prescaler u_pre (
        .i_ref_clk(i_ref_clk),
        .i_reset(i_reset),
        .i_run(run),
        .i_clear(clr),
        .i_select(i_cfg.prescale_select),
        .o_tick(tick)
    );
    always_comb begin
        count_d = count_q;
        post_d = post_q;
        flag_d = flag_q;
        pulse_d = 1'b0;
        out_d = out_q;
        event_hit = 1'b0;
        post_hit = 1'b0;
        if (i_flag_clear) begin
            flag_d = 1'b0;
        end
        if (tick && !clr) begin
            if (i_cfg.mode_16bit) begin
                event_hit = (count_q == `TIMER_COUNT_COUNT_MAX); // [RULE8]
                count_d = count_q + 16'h0001; // [RULE17]
            end else begin
                event_hit = (count_q[7:0] == count_q[15:8]); // [RULE7]
                // Match restarts the low byte so the compare sets the period. [RULE16]
                count_d[7:0] = event_hit ? 8'h00 : count_q[7:0] + 8'h01;
            end
        end
        // Software writes come last so a same-cycle tick cannot undo them.
        if (i_wr.wr_low) begin
            count_d[7:0] = i_wr.data;
        end
        if (i_wr.wr_high) begin
            count_d[15:8] = i_wr.data;
        end
        if (clr) begin
            post_d = '0; // [RULE5]
        end else if (event_hit) begin
            // Divide events by postscale select plus one. [RULE4] [RULE9]
            post_hit = (post_q >= i_cfg.postscale_select);
            post_d = post_hit ? '0 : post_q + 4'h1;
        end
        if (post_hit) begin
            flag_d = 1'b1; // Set beats a same-cycle clear. [RULE9]
            pulse_d = 1'b1; // [RULE11]
            out_d = ~out_q; // [RULE12]
        end
    end
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            count_q <= `TIMER_COUNT_COUNT_RESET;
            post_q <= '0;
            flag_q <= 1'b0;
            pulse_q <= 1'b0;
            out_q <= 1'b0;
            irq_q <= 1'b0;
            wake_q <= 1'b0;
            adc_q <= 1'b0;
            pin_q <= '0;
        end else begin
            count_q <= count_d;
            post_q <= post_d;
            flag_q <= flag_d;
            pulse_q <= pulse_d;
            out_q <= out_d;
            irq_q <= flag_d & i_irq_enable; // [RULE10]
            wake_q <= flag_d & i_irq_enable & i_sleep; // [RULE6] [RULE10]
            adc_q <= out_d; // [RULE14]
            pin_q <= {PINS{out_d}} & i_pin_select; // [RULE15]
        end
    end
    assign o_timer_count = count_q;
    assign o_timer_irq_flag = flag_q;
    assign o_irq = irq_q;
    assign o_wake = wake_q;
    assign o_timer_pulse_out = pulse_q;
    assign o_timer_out = out_q;
    assign o_out_status = out_q; // [RULE13]
    assign o_adc_trigger = adc_q;
    assign o_pin_out = pin_q;
endmodule
`default_nettype wire

// file: test/timer_count_timer_asserts.sv
// Checker for the timer-counter top.
// Assumes one clock and a synchronous active-high reset.
`default_nettype none
module timer_count_timer_asserts #(
    parameter int PINS = 16
) (
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire timer_count_pkg::timer_count_cfg_t i_cfg,
    input wire timer_count_pkg::timer_count_wr_t i_wr,
    input wire logic i_sleep,
    input wire logic i_irq_enable,
    input wire logic [PINS-1:0] i_pin_select,
    input wire logic o_irq,
    input wire logic o_wake,
    input wire logic [15:0] o_timer_count,
    input wire logic o_timer_irq_flag,
    input wire logic o_timer_pulse_out,
    input wire logic o_timer_out,
    input wire logic o_out_status,
    input wire logic o_adc_trigger,
    input wire logic [PINS-1:0] o_pin_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_ref_clk);
    endclocking
    default disable iff (i_reset);
    sequence at_top_s;
        o_timer_count == 16'hffff && i_cfg == {3'h6, 8'h00} && !i_sleep && i_wr == '0;
    endsequence
    wrap_event_a: assert property (at_top_s |=> o_timer_pulse_out)
        else $error("No event on wrap.");
    match_zero_a: assert property (o_timer_pulse_out && !$past(i_cfg.mode_16bit)
        |-> o_timer_count[7:0] == 8'h00) else $error("Low byte not cleared.");
    flag_set_a: assert property (o_timer_pulse_out |-> o_timer_irq_flag)
        else $error("Flag not set.");
    out_toggle_a: assert property (o_timer_pulse_out |-> o_timer_out != $past(o_timer_out))
        else $error("Output did not toggle.");
    out_mirror_a: assert property (o_out_status == o_timer_out && o_adc_trigger == o_timer_out)
        else $error("Output copies differ.");
    pin_route_a: assert property ($stable(o_timer_out)
        |-> o_pin_out == ({PINS{o_timer_out}} & $past(i_pin_select))) else $error("Pin wrong.");
    sleep_halt_a: assert property (i_sleep && !i_cfg.async_clk && i_wr == '0
        |=> $stable(o_timer_count)) else $error("Counted in sleep.");
    hold_off_a: assert property (!i_cfg.enable && i_wr == '0 |=> $stable(o_timer_count))
        else $error("Counted while off.");
    irq_gate_a: assert property (o_irq == (o_timer_irq_flag && $past(i_irq_enable)))
        else $error("Interrupt does not follow flag and enable.");
    wake_gate_a: assert property (o_wake == (o_irq && $past(i_sleep)))
        else $error("Wake does not follow interrupt in sleep.");
endmodule
`default_nettype wire

// file: test/timer_count_irq_ctl.sv
// Interrupt controller model: clears the flag a few cycles after it is raised.
// Assumes the timer's clock and reset.
`default_nettype none
module timer_count_irq_ctl (
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic i_irq,
    output logic o_flag_clear
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] wait_q = 3'h0;
    initial o_flag_clear = 1'b0;
    always @(posedge i_ref_clk) begin
        wait_q <= (i_reset || !i_irq) ? 3'h0 : wait_q + 3'h1;
        o_flag_clear <= wait_q == 3'h4;
    end
endmodule
`default_nettype wire

// file: test/timer_count_timer_bench.sv
// Bench for the timer-counter: gaps between postscaled pulses are checked.
// Assumes the design, checker and controller model are compiled first.
`default_nettype none
module timer_count_timer_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst = 1'b1, slp = 1'b0, clr, irq, pulse;
    logic [15:0] sel = 16'h0000;
    timer_count_pkg::timer_count_cfg_t cfg = '0;
    timer_count_pkg::timer_count_wr_t wr = '0;
    int error_cnt = 0, n_tests = 0, gap = 0, exp_q[$];
    bit busy = 1'b1, armed = 1'b0;
    initial forever #10 clk = ~clk;
    timer_count_timer DUT (.i_ref_clk(clk), .i_reset(rst), .i_cfg(cfg), .i_wr(wr), .i_sleep(slp),
        .i_irq_enable(1'b1), .i_flag_clear(clr), .i_pin_select(sel), .o_timer_count(),
        .o_timer_irq_flag(), .o_irq(irq), .o_wake(), .o_timer_pulse_out(pulse),
        .o_timer_out(), .o_out_status(), .o_adc_trigger(), .o_pin_out());
    timer_count_irq_ctl CTL (.i_ref_clk(clk), .i_reset(rst), .i_irq(irq), .o_flag_clear(clr));
    // The first pulse after a reconfiguration has a partial gap, so it only arms the check.
    always @(posedge clk) begin
        gap <= gap + 1;
        if (busy) begin
            armed <= 1'b0;
        end
        if (pulse === 1'b1) begin
            gap <= 1;
            armed <= !busy;
            if (armed && exp_q.size() > 0) begin
                n_tests++;
                if (gap !== exp_q.pop_front()) begin
                    error_cnt++;
                    $display("[FAIL] %0t gap %0d", $time, gap);
                end
            end
        end
    end
    task automatic print_verdict();
        $display("Checks %0d, errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic run(input logic [3:0] s, input logic [3:0] p, input logic [7:0] h);
        int i;
        busy = 1'b1;
        cfg = {3'h4, p, s};
        wr = {3'h2, h};
        @(posedge clk) #1;
        wr = {3'h5, 8'h00};
        @(posedge clk) #1;
        wr = '0;
        busy = 1'b0;
        for (i = 0; i < 3; i++) exp_q.push_back((int'(h) + 1) * (int'(p) + 1) << s);
        for (i = 0; i < 9000 && exp_q.size() > 0; i++) @(posedge clk) #1;
        if (exp_q.size() > 0) begin
            error_cnt++;
            $display("[FAIL] %0t no pulse", $time);
            print_verdict();
        end
    endtask
    initial begin
        void'($urandom(32'h4ee5a21b));
        repeat (3) @(posedge clk);
        #1 rst = 1'b0;
        run(4'h0, 4'h0, 8'h00);
        run(4'h1, 4'hf, 8'h02);
        repeat (4) begin
            sel = 16'($urandom);
            run(4'($urandom % 4), 4'($urandom % 4), 8'($urandom % 16));
        end
        slp = 1'b1;
        repeat (20) @(posedge clk) #1;
        cfg.async_clk = 1'b1;
        repeat (20) @(posedge clk) #1;
        slp = 1'b0;
        cfg.enable = 1'b0;
        repeat (20) @(posedge clk) #1;
        cfg = {3'h6, 8'h00};
        wr = {3'h2, 8'hff};
        @(posedge clk) #1;
        wr = {3'h4, 8'hfc};
        @(posedge clk) #1;
        wr = '0;
        repeat (8) @(posedge clk) #1;
        print_verdict();
    end
endmodule
bind timer_count_timer timer_count_timer_asserts #(.PINS(PINS)) CHK (.*);
`default_nettype wire
